// >>> igsc_group_ctl.sv
// IMA group state control: link state evaluation, group state machine, GSC signalling
`timescale 1ns/1ps
`default_nettype none
module igsc_group_ctl #(
	parameter int LINKS = 8,
	parameter int HOLD_TICKS = igsc_pkg::IGSC_HOLD_TICKS
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Management configuration
	input wire logic cfg_en_i,
	input wire logic [1:0] cfg_mode_i,
	input wire logic [$clog2(LINKS):0] cfg_p_tx_i,
	input wire logic [$clog2(LINKS):0] cfg_p_rx_i,
	input wire logic [LINKS-1:0] cfg_inhibit_i,
	input wire logic [2:0] cfg_reason_i,
	// Received ICP information per link
	input wire logic [LINKS-1:0] icp_chg_i,
	input wire logic [LINKS-1:0] fe_tx_up_i,
	input wire logic [LINKS-1:0] fe_rx_up_i,
	input wire logic [LINKS-1:0] link_fail_i,
	input wire logic [LINKS-1:0] rx_ids_ok_i,
	input wire logic fe_cfg_bad_i,
	input wire logic fe_gsm_oper_i,
	input wire logic fe_gsm_startup_i,
	// Transmit frame timing
	input wire logic frame_start_i,
	// Outputs to ICP generator and management
	output logic [3:0] gsc_code_o,
	output logic [3*LINKS-1:0] tx_state_o,
	output logic [3*LINKS-1:0] rx_state_o,
	output logic [3*LINKS-1:0] unus_reason_o,
	output logic [LINKS-1:0] sync_ref_o,
	output logic [2:0] gsm_state_o,
	output logic group_up_o,
	output logic [$clog2(LINKS):0] p_tx_o,
	output logic [$clog2(LINKS):0] p_rx_o
);
	localparam int CW = $clog2(LINKS) + 1;
	igsc_ev_if #(.LINKS(LINKS)) ev ();
	igsc_ev_arb #(.LINKS(LINKS)) u_arb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.icp_chg_i(icp_chg_i),
		.fe_tx_up_i(fe_tx_up_i),
		.fe_rx_up_i(fe_rx_up_i),
		.link_fail_i(link_fail_i),
		.ev(ev)
	);

	igsc_pkg::igsc_lstate_t tx_st [LINKS];
	igsc_pkg::igsc_lstate_t rx_st [LINKS];
	igsc_pkg::igsc_gstate_t gst;
	igsc_pkg::igsc_gstate_t next_gst;

	// Thresholds: clamp at one, tie in symmetric-symmetric mode
	wire logic [CW-1:0] p_tx_cl = (cfg_p_tx_i == '0) ? CW'(1) : cfg_p_tx_i;
	wire logic [CW-1:0] p_rx_cl = (cfg_p_rx_i == '0) ? CW'(1) : cfg_p_rx_i;
	wire logic sym_sym = (cfg_mode_i == igsc_pkg::IGSC_MODE_SYM_SYM);
	wire logic asym = (cfg_mode_i == igsc_pkg::IGSC_MODE_ASYM_ASYM);
	wire logic [CW-1:0] p_max = (p_tx_cl > p_rx_cl) ? p_tx_cl : p_rx_cl;
	wire logic [CW-1:0] p_tx = sym_sym ? p_max : p_tx_cl;
	wire logic [CW-1:0] p_rx = sym_sym ? p_max : p_rx_cl;
	assign p_tx_o = p_tx;
	assign p_rx_o = p_rx;

	// Per-link state evaluation on serialised events
	wire logic [LINKS-1:0] tx_act;
	wire logic [LINKS-1:0] rx_act;
	wire logic ev_link_ok = ev.valid && !ev.fail && !cfg_inhibit_i[ev.link];
	// Symmetric modes pair Tx and Rx; Tx Active without Rx Active is invalid
	wire logic pair_ok = asym || !(ev.tx_up && !ev.rx_up);
	wire logic startup_ok = (gst == igsc_pkg::IGSC_G_START_UP_ACK) || (gst == igsc_pkg::IGSC_G_OPERATIONAL)
		|| (gst == igsc_pkg::IGSC_G_INSUFF_LINKS);
	genvar g;
	generate
		for (g = 0; g < LINKS; g++) begin : g_link
			wire logic hit = ev.valid && (ev.link == (CW-1)'(g));
			always_ff @(posedge clk_i) begin
				if (rst_i || !cfg_en_i) begin
					tx_st[g] <= igsc_pkg::IGSC_LS_NOT_IN_GROUP;
					rx_st[g] <= igsc_pkg::IGSC_LS_NOT_IN_GROUP;
				end else if (hit) begin
					// Both directions re-evaluated on each changed ICP cell
					if (!ev_link_ok) begin
						tx_st[g] <= igsc_pkg::IGSC_LS_UNUSABLE;
						rx_st[g] <= igsc_pkg::IGSC_LS_UNUSABLE;
					end else if (!startup_ok) begin
						tx_st[g] <= igsc_pkg::IGSC_LS_USABLE;
						rx_st[g] <= igsc_pkg::IGSC_LS_USABLE;
					end else if (pair_ok) begin
						tx_st[g] <= ev.rx_up ? igsc_pkg::IGSC_LS_ACTIVE : igsc_pkg::IGSC_LS_USABLE;
						rx_st[g] <= ev.tx_up ? igsc_pkg::IGSC_LS_ACTIVE : igsc_pkg::IGSC_LS_USABLE;
					end else begin
						tx_st[g] <= igsc_pkg::IGSC_LS_USABLE;
						rx_st[g] <= igsc_pkg::IGSC_LS_USABLE;
					end
				end
			end
			assign tx_act[g] = (tx_st[g] == igsc_pkg::IGSC_LS_ACTIVE);
			assign rx_act[g] = (rx_st[g] == igsc_pkg::IGSC_LS_ACTIVE);
			// Fields change in the same cycle as the state: well inside 2*M cells
			assign tx_state_o[3*g +: 3] = tx_st[g];
			assign rx_state_o[3*g +: 3] = rx_st[g];
			assign unus_reason_o[3*g +: 3] = (tx_st[g] == igsc_pkg::IGSC_LS_UNUSABLE) ?
				(cfg_inhibit_i[g] ? igsc_pkg::IGSC_RSN_INHIBITED : cfg_reason_i) : igsc_pkg::IGSC_RSN_NONE;
		end
	endgenerate

	// Active link counts
	logic [CW-1:0] n_tx;
	logic [CW-1:0] n_rx;
	always_comb begin
		n_tx = '0;
		n_rx = '0;
		for (int i = 0; i < LINKS; i++) begin
			n_tx = n_tx + CW'(tx_act[i]);
			n_rx = n_rx + CW'(rx_act[i]);
		end
	end
	wire logic thr_ok = (n_tx >= p_tx) && (n_rx >= p_rx);
	wire logic ids_ok = |rx_ids_ok_i;
	assign sync_ref_o = rx_ids_ok_i;

	// One-second timebase: microsecond tick, held cleared until Config-Aborted is on the wire,
	// so the whole second is counted from the code the far end actually sees
	logic [7:0] tick_cnt;
	logic [31:0] hold_cnt;
	wire logic tick = (tick_cnt == 8'(igsc_pkg::IGSC_TICK_CYCLES - 1));
	wire logic abort_sent = (gsc_code_o == igsc_pkg::IGSC_GSC_CFG_ABORTED);
	wire logic hold_done = (hold_cnt >= 32'(HOLD_TICKS));
	always_ff @(posedge clk_i) begin
		if (rst_i || !abort_sent) begin
			tick_cnt <= '0;
			hold_cnt <= '0;
		end else begin
			tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
			if (tick && !hold_done) begin
				hold_cnt <= hold_cnt + 32'h1;
			end
		end
	end

	// Group state machine
	always_comb begin
		next_gst = gst;
		if (!cfg_en_i) begin
			next_gst = igsc_pkg::IGSC_G_NOT_CONFIGURED;
		end else begin
			unique case (gst)
				igsc_pkg::IGSC_G_NOT_CONFIGURED: next_gst = igsc_pkg::IGSC_G_START_UP;
				igsc_pkg::IGSC_G_START_UP: begin
					if (fe_cfg_bad_i) begin
						next_gst = igsc_pkg::IGSC_G_CFG_ABORTED;
					end else if (ids_ok && (fe_gsm_startup_i || fe_gsm_oper_i)) begin
						next_gst = igsc_pkg::IGSC_G_START_UP_ACK;
					end
				end
				igsc_pkg::IGSC_G_START_UP_ACK: begin
					if (fe_cfg_bad_i) begin
						next_gst = igsc_pkg::IGSC_G_CFG_ABORTED;
					end else if (!ids_ok) begin
						next_gst = igsc_pkg::IGSC_G_START_UP;
					end else if (thr_ok) begin
						next_gst = igsc_pkg::IGSC_G_OPERATIONAL;
					end
				end
				igsc_pkg::IGSC_G_CFG_ABORTED: begin
					if (hold_done && !fe_cfg_bad_i) begin
						next_gst = igsc_pkg::IGSC_G_START_UP;
					end
				end
				igsc_pkg::IGSC_G_INSUFF_LINKS: begin
					if (!ids_ok) begin
						next_gst = igsc_pkg::IGSC_G_START_UP;
					end else if (thr_ok) begin
						next_gst = igsc_pkg::IGSC_G_OPERATIONAL;
					end
				end
				igsc_pkg::IGSC_G_BLOCKED: next_gst = igsc_pkg::IGSC_G_INSUFF_LINKS;
				igsc_pkg::IGSC_G_OPERATIONAL: begin
					if (!ids_ok) begin
						next_gst = igsc_pkg::IGSC_G_START_UP;
					end else if (!thr_ok) begin
						next_gst = igsc_pkg::IGSC_G_INSUFF_LINKS;
					end
				end
				default: next_gst = igsc_pkg::IGSC_G_NOT_CONFIGURED;
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gst <= igsc_pkg::IGSC_G_NOT_CONFIGURED;
		end else begin
			gst <= next_gst;
		end
	end
	assign gsm_state_o = gst;

	// GSC code wanted for the current state
	logic [3:0] gsc_want;
	always_comb begin
		unique case (gst)
			igsc_pkg::IGSC_G_START_UP_ACK: gsc_want = igsc_pkg::IGSC_GSC_START_UP_ACK;
			igsc_pkg::IGSC_G_CFG_ABORTED: gsc_want = igsc_pkg::IGSC_GSC_CFG_ABORTED;
			igsc_pkg::IGSC_G_INSUFF_LINKS: gsc_want = igsc_pkg::IGSC_GSC_INSUFF_LINKS;
			igsc_pkg::IGSC_G_BLOCKED: gsc_want = igsc_pkg::IGSC_GSC_BLOCKED;
			igsc_pkg::IGSC_G_OPERATIONAL: gsc_want = igsc_pkg::IGSC_GSC_OPERATIONAL;
			default: gsc_want = igsc_pkg::IGSC_GSC_START_UP; // Not Configured sends Start-up
		endcase
	end

	// Sent code changes only at a frame start after two whole frames
	logic [1:0] gsc_frames;
	wire logic gsc_may_change = frame_start_i && (gsc_frames >= 2'(igsc_pkg::IGSC_GSC_HOLD_FRAMES));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gsc_code_o <= igsc_pkg::IGSC_GSC_START_UP;
			gsc_frames <= '0;
		end else if (gsc_may_change && (gsc_want != gsc_code_o)) begin
			gsc_code_o <= gsc_want;
			gsc_frames <= 2'h1;
		end else if (frame_start_i && (gsc_frames != 2'h3)) begin
			gsc_frames <= gsc_frames + 2'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			group_up_o <= 1'b0;
		end else begin
			group_up_o <= (gst == igsc_pkg::IGSC_G_OPERATIONAL) && fe_gsm_oper_i;
		end
	end
endmodule // igsc_group_ctl
`default_nettype wire

// >>> igsc_pkg.sv
// Shared constants and types for the IMA group state control block
package igsc_pkg;
	// Link state encodings carried in the Tx State / Rx State fields
	typedef enum logic [2:0] {
		IGSC_LS_NOT_IN_GROUP,
		IGSC_LS_UNUSABLE,
		IGSC_LS_USABLE,
		IGSC_LS_ACTIVE
	} igsc_lstate_t;
	// Unusable reason codes
	localparam logic [2:0] IGSC_RSN_NONE = 3'h0;
	localparam logic [2:0] IGSC_RSN_INHIBITED = 3'h1;
	localparam logic [2:0] IGSC_RSN_FAILED = 3'h2;
	localparam logic [2:0] IGSC_RSN_FAULT = 3'h3;
	localparam logic [2:0] IGSC_RSN_MISCONN = 3'h4;
	// Symmetry modes
	localparam logic [1:0] IGSC_MODE_SYM_SYM = 2'h0;
	localparam logic [1:0] IGSC_MODE_SYM_ASYM = 2'h1;
	localparam logic [1:0] IGSC_MODE_ASYM_ASYM = 2'h2;
	// Group Status and Control codes
	localparam logic [3:0] IGSC_GSC_START_UP = 4'h0;
	localparam logic [3:0] IGSC_GSC_START_UP_ACK = 4'h1;
	localparam logic [3:0] IGSC_GSC_CFG_ABORTED = 4'h2;
	localparam logic [3:0] IGSC_GSC_INSUFF_LINKS = 4'h3;
	localparam logic [3:0] IGSC_GSC_BLOCKED = 4'h4;
	localparam logic [3:0] IGSC_GSC_OPERATIONAL = 4'h5;
	// Frames that a GSC value must stand before it may change
	localparam int IGSC_GSC_HOLD_FRAMES = 2;
	// Timing: clock and one-second hold
	localparam int IGSC_CLK_MHZ = 125;
	localparam int IGSC_TICK_NS = 1000;
	localparam int IGSC_TICK_CYCLES = (IGSC_TICK_NS * IGSC_CLK_MHZ + 999) / 1000;
	localparam int IGSC_HOLD_MS = 1000;
	localparam int IGSC_HOLD_TICKS = IGSC_HOLD_MS * 1000;
	// Group state machine
	typedef enum logic [2:0] {
		IGSC_G_NOT_CONFIGURED,
		IGSC_G_START_UP,
		IGSC_G_START_UP_ACK,
		IGSC_G_CFG_ABORTED,
		IGSC_G_INSUFF_LINKS,
		IGSC_G_BLOCKED,
		IGSC_G_OPERATIONAL
	} igsc_gstate_t;
endpackage

// >>> igsc_ev_if.sv
// Carrier between the link event arbiter and the group controller
`timescale 1ns/1ps
`default_nettype none
interface igsc_ev_if #(parameter int LINKS = 8);
	logic valid;
	logic [$clog2(LINKS)-1:0] link;
	logic tx_up;
	logic rx_up;
	logic fail;
	modport arb (output valid, output link, output tx_up, output rx_up, output fail);
	modport ctl (input valid, input link, input tx_up, input rx_up, input fail);
endinterface
`default_nettype wire

// >>> igsc_ev_arb.sv
// Serialises simultaneous per-link ICP state events in fixed priority order
`timescale 1ns/1ps
`default_nettype none
module igsc_ev_arb #(
	parameter int LINKS = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Raw per-link events
	input wire logic [LINKS-1:0] icp_chg_i,
	input wire logic [LINKS-1:0] fe_tx_up_i,
	input wire logic [LINKS-1:0] fe_rx_up_i,
	input wire logic [LINKS-1:0] link_fail_i,
	// Serialised events
	igsc_ev_if.arb ev
);
	logic [LINKS-1:0] pend;
	logic [LINKS-1:0] fail_pend;
	logic [LINKS-1:0] grant;
	logic [LINKS-1:0] next_pend;
	logic [LINKS-1:0] next_fail;
	logic [$clog2(LINKS)-1:0] sel;
	// Lowest link number first; latch events so none are merged or lost
	assign next_pend = pend | icp_chg_i | link_fail_i;
	// A failure waiting behind a lower link is kept until its own grant
	assign next_fail = fail_pend | link_fail_i;
	assign grant = next_pend & (~next_pend + {{(LINKS-1){1'b0}}, 1'b1});
	always_comb begin
		sel = '0;
		for (int i = 0; i < LINKS; i++) begin
			if (grant[i]) begin
				sel = i[$clog2(LINKS)-1:0];
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend <= '0;
			fail_pend <= '0;
			ev.valid <= 1'b0;
			ev.link <= '0;
			ev.tx_up <= 1'b0;
			ev.rx_up <= 1'b0;
			ev.fail <= 1'b0;
		end else begin
			pend <= next_pend & ~grant;
			fail_pend <= next_fail & ~grant;
			ev.valid <= |next_pend;
			ev.link <= sel;
			ev.tx_up <= fe_tx_up_i[sel];
			ev.rx_up <= fe_rx_up_i[sel];
			ev.fail <= next_fail[sel];
		end
	end
endmodule // igsc_ev_arb
`default_nettype wire

// >>> igsc_group_ctl_properties.sv
// Concurrent checks on the ports of the IMA group state control block
`timescale 1ns/1ps
`default_nettype none
module igsc_group_ctl_properties #(
	parameter int LINKS = 8,
	parameter int HOLD_TICKS = igsc_pkg::IGSC_HOLD_TICKS
) (
	// Clock, reset and inputs
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [1:0] cfg_mode_i,
	input wire logic [$clog2(LINKS):0] cfg_p_tx_i,
	input wire logic [LINKS-1:0] rx_ids_ok_i,
	input wire logic fe_cfg_bad_i,
	input wire logic fe_gsm_oper_i,
	input wire logic frame_start_i,
	// Outputs
	input wire logic [3:0] gsc_code_o,
	input wire logic [LINKS-1:0] sync_ref_o,
	input wire logic [2:0] gsm_state_o,
	input wire logic group_up_o,
	input wire logic [$clog2(LINKS):0] p_tx_o,
	input wire logic [$clog2(LINKS):0] p_rx_o
);
	localparam int ABORT_CYCLES = HOLD_TICKS * igsc_pkg::IGSC_TICK_CYCLES;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [3:0] gsc_q;
	logic [1:0] n_frames;
	int ab_cycles;
	logic up_cause;
	assign up_cause = gsm_state_o == 3'h6 && fe_gsm_oper_i;
	// Frame starts seen since the last GSC change, and cycles spent in Config-Aborted
	always_ff @(posedge clk_i) begin
		gsc_q <= gsc_code_o;
		ab_cycles <= (gsm_state_o == 3'h3) ? ab_cycles + 1 : 0;
		if (rst_i)
			n_frames <= 2'h2;
		else if (gsc_code_o != gsc_q)
			n_frames <= {1'b0, frame_start_i};
		else if (frame_start_i && n_frames != 2'h3)
			n_frames <= n_frames + 2'h1;
	end
	sequence s_enter(logic [2:0] st);
		gsm_state_o == st && $past(gsm_state_o) != st;
	endsequence
	sequence s_leave_abort;
		gsm_state_o != 3'h3 && $past(gsm_state_o) == 3'h3;
	endsequence
	a_gsc_code_range: assert property (gsc_code_o <= igsc_pkg::IGSC_GSC_OPERATIONAL)
		else $error("gsc code out of range");
	a_gsc_on_frame: assert property (gsc_code_o != gsc_q |-> $past(frame_start_i))
		else $error("gsc changed off a frame start");
	a_gsc_two_frames: assert property (gsc_code_o != gsc_q |-> n_frames >= 2'h2)
		else $error("gsc held under two frames");
	a_ack_needs_ids: assert property (s_enter(3'h2) |-> $past(|rx_ids_ok_i))
		else $error("start-up ack without validated link");
	a_sync_from_ids: assert property (sync_ref_o == rx_ids_ok_i)
		else $error("sync reference mismatch");
	a_oper_entry_from: assert property (s_enter(3'h6) |-> $past(gsm_state_o) inside {3'h2, 3'h4, 3'h5})
		else $error("operational entered from wrong state");
	a_thresh_nonzero: assert property (p_tx_o != '0 && p_rx_o != '0)
		else $error("zero threshold");
	a_sym_thresh_equal: assert property (cfg_mode_i == igsc_pkg::IGSC_MODE_SYM_SYM |-> p_tx_o == p_rx_o)
		else $error("sym thresholds differ");
	a_tx_thresh_own: assert property (cfg_mode_i == 2'h2 && cfg_p_tx_i != '0 |-> p_tx_o == cfg_p_tx_i)
		else $error("tx threshold not as configured");
	a_group_up_cause: assert property (group_up_o == $past(up_cause))
		else $error("group up mismatch");
	a_abort_hold: assert property (s_leave_abort |-> ab_cycles >= ABORT_CYCLES)
		else $error("config aborted left too early");
	a_abort_cause: assert property (s_enter(3'h3) |-> $past(fe_cfg_bad_i))
		else $error("config aborted without cause");
endmodule // igsc_group_ctl_properties
bind igsc_group_ctl igsc_group_ctl_properties #(.LINKS(LINKS), .HOLD_TICKS(HOLD_TICKS)) u_props (
	.clk_i, .rst_i, .cfg_mode_i, .cfg_p_tx_i, .rx_ids_ok_i, .fe_cfg_bad_i, .fe_gsm_oper_i, .frame_start_i,
	.gsc_code_o, .sync_ref_o, .gsm_state_o, .group_up_o, .p_tx_o, .p_rx_o
);
`default_nettype wire

// >>> igsc_fe_model.sv
// Behavioural far-end IMA unit sending ICP state changes
`timescale 1ns/1ps
`default_nettype none
module igsc_fe_model #(
	parameter int LINKS = 8
) (
	// Clock and commanded far-end link activity
	input wire logic clk_i,
	input wire logic [LINKS-1:0] tx_i,
	input wire logic [LINKS-1:0] rx_i,
	input wire logic [3:0] gsc_code_i,
	// ICP information toward the device
	output logic [LINKS-1:0] icp_chg_o,
	output logic [LINKS-1:0] fe_tx_up_o,
	output logic [LINKS-1:0] fe_rx_up_o,
	output logic fe_gsm_oper_o,
	output logic fe_gsm_startup_o
);
	initial begin
		icp_chg_o = '0;
		fe_tx_up_o = '0;
		fe_rx_up_o = '0;
	end
	// A cell with new state only when the far-end state moves; state held until the next change
	always @(posedge clk_i) begin
		icp_chg_o <= (tx_i ^ fe_tx_up_o) | (rx_i ^ fe_rx_up_o);
		fe_tx_up_o <= tx_i;
		fe_rx_up_o <= rx_i;
	end
	// Far end reports Operational while the local group sends Start-up-Ack or Operational
	assign fe_gsm_oper_o = gsc_code_i == igsc_pkg::IGSC_GSC_START_UP_ACK || gsc_code_i == igsc_pkg::IGSC_GSC_OPERATIONAL;
	assign fe_gsm_startup_o = !fe_gsm_oper_o;
endmodule // igsc_fe_model
`default_nettype wire

// >>> igsc_group_ctl_tb_top.sv
// Self-checking testbench for the IMA group state control block
`timescale 1ns/1ps
`default_nettype none
module igsc_group_ctl_tb_top;
	logic clk_i = 1'b0, rst_i = 1'b1, cfg_en_i = 1'b0, fe_cfg_bad_i = 1'b0, frame_start_i = 1'b0;
	logic [1:0] cfg_mode_i = 2'h1, fcnt = 2'h0;
	logic [3:0] cfg_p_tx_i = 4'h2, cfg_p_rx_i = 4'h2, gsc_code_o, p_tx_o, p_rx_o;
	logic [2:0] cfg_reason_i = 3'h2, gsm_state_o;
	logic [7:0] cfg_inhibit_i = 8'h00, link_fail_i = 8'h00, rx_ids_ok_i = 8'h00, tx_cmd = 8'h00, rx_cmd = 8'h00;
	logic [7:0] icp_chg_i, fe_tx_up_i, fe_rx_up_i, sync_ref_o;
	logic fe_gsm_oper_i, fe_gsm_startup_i, group_up_o;
	logic [23:0] tx_state_o, rx_state_o, unus_reason_o;
	logic [31:0] lfsr = 32'h6c41c8e6;
	int n_errors = 0;
	int total_checks = 0;
	typedef struct {int sel; logic [5:0] exp;} igsc_note_t;
	igsc_note_t notes[$];
	event chk_ev;
	igsc_group_ctl #(.LINKS(8), .HOLD_TICKS(20)) dut (
		.clk_i, .rst_i, .cfg_en_i, .cfg_mode_i, .cfg_p_tx_i, .cfg_p_rx_i, .cfg_inhibit_i, .cfg_reason_i,
		.icp_chg_i, .fe_tx_up_i, .fe_rx_up_i, .link_fail_i, .rx_ids_ok_i, .fe_cfg_bad_i, .fe_gsm_oper_i,
		.fe_gsm_startup_i, .frame_start_i, .gsc_code_o, .tx_state_o, .rx_state_o, .unus_reason_o,
		.sync_ref_o, .gsm_state_o, .group_up_o, .p_tx_o, .p_rx_o
	);
	igsc_fe_model #(.LINKS(8)) u_fe (.clk_i, .tx_i(tx_cmd), .rx_i(rx_cmd), .gsc_code_i(gsc_code_o),
		.icp_chg_o(icp_chg_i), .fe_tx_up_o(fe_tx_up_i), .fe_rx_up_o(fe_rx_up_i),
		.fe_gsm_oper_o(fe_gsm_oper_i), .fe_gsm_startup_o(fe_gsm_startup_i));
	always #4 clk_i = ~clk_i;
	// Transmit IMA frame every four cycles
	always @(negedge clk_i) begin
		fcnt <= fcnt + 2'h1;
		frame_start_i <= fcnt == 2'h3;
	end
	function automatic logic [5:0] observe(input int sel);
		if (sel < 8)
			return {tx_state_o[3*sel+:3], rx_state_o[3*sel+:3]};
		if (sel > 15)
			return {3'h0, unus_reason_o[3*(sel-16)+:3]};
		case (sel)
			8: return {3'h0, gsm_state_o};
			9: return {2'h0, gsc_code_o};
			10: return {5'h0, group_up_o};
			11: return {2'h0, p_tx_o};
			13: return sync_ref_o[5:0];
			default: return {2'h0, p_rx_o};
		endcase
	endfunction
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [5:0] seen, input logic [5:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic note(input int sel, input logic [5:0] exp);
		notes.push_back('{sel, exp});
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge clk_i);
		->chk_ev;
		@(negedge clk_i);
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_gsm(input logic [2:0] st, output int cyc);
		cyc = 0;
		while (gsm_state_o !== st) begin
			@(negedge clk_i);
			cyc++;
			if (cyc > 4000) begin
				check({3'h0, gsm_state_o}, {3'h0, st});
				print_verdict();
			end
		end
	endtask
	// Monitor: compares outputs against the oldest pending notes
	initial forever begin
		@(chk_ev);
		while (notes.size() > 0) begin
			check(observe(notes[0].sel), notes[0].exp);
			void'(notes.pop_front());
		end
	end
	initial begin
		int cyc;
		int r;
		repeat (3) @(negedge clk_i);
		note(8, 6'h0);
		note(9, 6'h0);
		note(10, 6'h0);
		settle(0);
		rst_i = 1'b0;
		cfg_mode_i = 2'h0;
		cfg_p_tx_i = 4'h1;
		cfg_p_rx_i = 4'h3;
		note(11, 6'h3);
		settle(1);
		cfg_mode_i = 2'h2;
		cfg_p_tx_i = 4'h0;
		note(11, 6'h1);
		note(12, 6'h3);
		settle(1);
		cfg_mode_i = 2'h1;
		cfg_p_tx_i = 4'h2;
		cfg_p_rx_i = 4'h2;
		cfg_en_i = 1'b1;
		wait_gsm(3'h1, cyc);
		tx_cmd = 8'h09;
		rx_cmd = 8'h09;
		note(0, 6'h12);
		note(3, 6'h12);
		settle(8);
		fe_cfg_bad_i = 1'b1;
		wait_gsm(3'h3, cyc);
		fe_cfg_bad_i = 1'b0;
		wait_gsm(3'h1, cyc);
		check({5'h0, cyc >= 20 * igsc_pkg::IGSC_TICK_CYCLES && cyc < 2600}, 6'h1);
		rx_ids_ok_i = 8'h01;
		note(13, 6'h01);
		wait_gsm(3'h2, cyc);
		tx_cmd[1] = 1'b1;
		rx_cmd[1] = 1'b1;
		note(1, 6'h1b);
		note(8, 6'h2);
		settle(8);
		tx_cmd[0] = 1'b0;
		rx_cmd[0] = 1'b0;
		settle(4);
		tx_cmd[0] = 1'b1;
		rx_cmd[0] = 1'b1;
		wait_gsm(3'h6, cyc);
		note(0, 6'h1b);
		note(9, 6'h5);
		note(10, 6'h1);
		settle(40);
		lfsr = lfsr_next(lfsr);
		r = 4 + int'(lfsr[1:0]);
		tx_cmd[r] = 1'b1;
		note(r, 6'h12);
		settle(8);
		cfg_mode_i = 2'h2;
		tx_cmd[r] = 1'b0;
		settle(4);
		tx_cmd[r] = 1'b1;
		note(r, 6'h13);
		settle(8);
		link_fail_i[1] = 1'b1;
		note(1, 6'h09);
		note(8, 6'h4);
		settle(8);
		for (int i = 2; i < 5; i++) begin
			cfg_reason_i = 3'(i);
			note(17, 6'(i));
			settle(1);
		end
		cfg_inhibit_i[1] = 1'b1;
		note(17, 6'h1);
		note(10, 6'h0);
		settle(1);
		print_verdict();
	end
endmodule // igsc_group_ctl_tb_top
`default_nettype wire
